// [verilog/t2_baud_pkg.sv]
/*
 * Package: register offsets, field positions, reset values and counts
 * for the timer 2 and serial baud clocking block.
 * Assumes: a single 100 MHz peripheral clock domain.
 */
package t2_baud_pkg;

   // ************************************************************
   // register offsets (8-bit special function space)
   // ************************************************************
   localparam logic [7:0] OFS_UART0_BUFFER   = 8'h99;
   localparam logic [7:0] OFS_BRG0_RELOAD    = 8'h9A;
   localparam logic [7:0] OFS_BRG0_CONTROL   = 8'h9B;
   localparam logic [7:0] OFS_BRG1_RELOAD    = 8'hBB;
   localparam logic [7:0] OFS_BRG1_CONTROL   = 8'hBC;
   localparam logic [7:0] OFS_UART1_BUFFER   = 8'hC1;
   localparam logic [7:0] OFS_TIMER2_CONTROL = 8'hC8;
   localparam logic [7:0] OFS_T2_RELOAD_LO   = 8'hCA;
   localparam logic [7:0] OFS_T2_RELOAD_HI   = 8'hCB;
   localparam logic [7:0] OFS_T2_COUNT_LO    = 8'hCC;
   localparam logic [7:0] OFS_T2_COUNT_HI    = 8'hCD;
   localparam logic [7:0] OFS_T1_CONTROL     = 8'hD0;
   localparam logic [7:0] OFS_IRQ_STATUS     = 8'hD1;
   localparam logic [7:0] OFS_IRQ_MASK       = 8'hD2;

   // ************************************************************
   // timer2_control fields
   // ************************************************************
   localparam int T2C_OVF   = 7;
   localparam int T2C_EXF   = 6;
   localparam int T2C_RCLK  = 5;
   localparam int T2C_TX_CLOCK_SELECT  = 4;
   localparam int T2C_EXEN  = 3;
   localparam int T2C_RUN   = 2;
   localparam int T2C_CT    = 1;
   localparam int T2C_CPRL  = 0;

   // ************************************************************
   // generator_control fields
   // ************************************************************
   localparam int GC_RUN   = 4;
   localparam int GC_TXSEL = 3;
   localparam int GC_RXSEL = 2;
   localparam int GC_FAST  = 1;
   localparam int GC_SRC   = 0;

   // serial control bits: [0] double_rate_bit, [2:1] serial mode
   localparam int SC_DOUBLE = 0;
   localparam int SC_MODE_L = 1;

   // interrupt status bits
   localparam int IRQ_T2OVF = 0;
   localparam int IRQ_T2EXT = 1;

   // ************************************************************
   // reset values and counts
   // ************************************************************
   localparam logic [7:0]  RST_BYTE       = 8'h00;
   localparam logic [15:0] RST_WORD       = 16'h0000;
   localparam logic [3:0]  OSC_DIV12_LAST = 4'hB;
   localparam logic [2:0]  SLOW_DIV_LAST  = 3'h5;

endpackage : t2_baud_pkg

// [verilog/baud_generator.sv]
/*
 * One internal baud rate generator: 8-bit up counter reloaded from
 * software, optional slow prescale, one-cycle tick at overflow.
 * Assumes: reload written over the register port, same clock.
 */
`timescale 1ns/1ps
module baud_generator
   import t2_baud_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   // control
   input  wire logic       run,
   input  wire logic       fast,
   input  wire logic [7:0] reloadValue,
   // output
   output logic            tick
);

   logic [7:0] count_q;
   logic [2:0] pre_q;
   logic       step;
   logic       wrap;

   // slow mode steps once every six clocks
   assign step = run & (fast | (pre_q == SLOW_DIV_LAST));
   assign wrap = step & (count_q == 8'hFF);

   always_ff @(posedge ref_clk) begin
      if (!reset_n || !run) begin
         pre_q <= 3'h0;
      end else begin
         pre_q <= (pre_q == SLOW_DIV_LAST) ? 3'h0 : pre_q + 3'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         count_q <= RST_BYTE;
         tick    <= 1'b0;
      end else begin
         tick <= wrap;
         if (wrap) begin
            count_q <= reloadValue;
         end else if (step) begin
            count_q <= count_q + 8'h01;
         end
      end
   end

endmodule : baud_generator

// [verilog/timer2_baud_clocking.sv]
/*
 * Timer 2 with capture/reload and external trigger, two internal
 * baud generators, serial clock selection and the two serial buffers.
 * Assumes: register port on ref_clk, pins asynchronous, timer 1
 * overflow as a one-cycle pulse from logic on the same clock.
 */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module timer2_baud_clocking
   import t2_baud_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   // register port
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   output logic      [7:0] regRdata,
   // pins and neighbours
   input  wire logic       count_input_pin,
   input  wire logic       ext_trigger_pin,
   input  wire logic       timer1Overflow,
   // serial bit clocks, one per channel
   output logic      [1:0] txBitClock,
   output logic      [1:0] rxBitClock,
   // interrupt
   output logic            irq
);

   // ************************************************************
   // registers
   // ************************************************************
   logic [7:0]  t2Ctrl_q;
   logic [15:0] t2Count_q;
   logic [15:0] t2Reload_q;
   logic [7:0]  uartBuf_q [2];
   logic [7:0]  brgReload_q [2];
   logic [4:0]  genCtrl_q [2];
   logic [2:0]  serCtrl_q [2];
   logic [1:0]  irqStat_q;
   logic [1:0]  irqMask_q;
   logic [3:0]  oscDiv_q;
   logic [1:0]  txHalf_q;
   logic [1:0]  rxHalf_q;
   logic [2:0]  cntSync_q;
   logic [2:0]  trgSync_q;

   // ************************************************************
   // register decode
   // ************************************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   wire wrCtrl   = regWrite & hit(regAddr, OFS_TIMER2_CONTROL);
   wire wrRldLo  = regWrite & hit(regAddr, OFS_T2_RELOAD_LO);
   wire wrRldHi  = regWrite & hit(regAddr, OFS_T2_RELOAD_HI);
   wire wrCntLo  = regWrite & hit(regAddr, OFS_T2_COUNT_LO);
   wire wrCntHi  = regWrite & hit(regAddr, OFS_T2_COUNT_HI);
   wire wrStat   = regWrite & hit(regAddr, OFS_IRQ_STATUS);
   wire wrMask   = regWrite & hit(regAddr, OFS_IRQ_MASK);
   wire [1:0] wrBuf = {regWrite & hit(regAddr, OFS_UART1_BUFFER),
                       regWrite & hit(regAddr, OFS_UART0_BUFFER)};
   wire [1:0] wrBrl = {regWrite & hit(regAddr, OFS_BRG1_RELOAD),
                       regWrite & hit(regAddr, OFS_BRG0_RELOAD)};
   wire [1:0] wrGen = {regWrite & hit(regAddr, OFS_BRG1_CONTROL),
                       regWrite & hit(regAddr, OFS_BRG0_CONTROL)};
   wire [1:0] wrSer = {regWrite & hit(regAddr, OFS_T1_CONTROL + 8'h04),
                       regWrite & hit(regAddr, OFS_T1_CONTROL)};

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   // two-stage sync, edge from later stages
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         cntSync_q <= 3'b111;
         trgSync_q <= 3'b111;
      end else begin
         cntSync_q <= {cntSync_q[1:0], count_input_pin};
         trgSync_q <= {trgSync_q[1:0], ext_trigger_pin};
      end
   end

   wire cntFall = cntSync_q[2] & ~cntSync_q[1];
   wire trgFall = trgSync_q[2] & ~trgSync_q[1];

   // ************************************************************
   // timer 2
   // ************************************************************
   wire serialUse = t2Ctrl_q[T2C_RCLK] | t2Ctrl_q[T2C_TX_CLOCK_SELECT];
   wire t2Step    = t2Ctrl_q[T2C_RUN] & (t2Ctrl_q[T2C_CT] ? cntFall : 1'b1);
   wire t2Ovf     = t2Step & (t2Count_q == 16'hFFFF);
   wire trgEvent  = t2Ctrl_q[T2C_EXEN] & trgFall;
   wire capMode   = t2Ctrl_q[T2C_CPRL] & ~serialUse;
   wire doReload  = t2Ovf | (trgEvent & ~capMode);
   wire doCapture = trgEvent & capMode;
   // overflow flag gated by serial use
   wire setOvf    = t2Ovf & ~serialUse;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         t2Count_q  <= RST_WORD;
         t2Reload_q <= RST_WORD;
      end else begin
         if (doCapture) begin
            t2Reload_q <= t2Count_q;
         end else begin
            if (wrRldLo) t2Reload_q[7:0]  <= regWdata;
            if (wrRldHi) t2Reload_q[15:8] <= regWdata;
         end
         if (doReload) begin
            t2Count_q <= t2Reload_q;
         end else if (wrCntLo) begin
            t2Count_q[7:0] <= regWdata;
         end else if (wrCntHi) begin
            t2Count_q[15:8] <= regWdata;
         end else if (t2Step) begin
            t2Count_q <= t2Count_q + 16'h0001;
         end
      end
   end

   // hardware set wins over a software clear in the same cycle
   wire [7:0] ctrlWr = wrCtrl ? regWdata : t2Ctrl_q;
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         t2Ctrl_q <= RST_BYTE;
      end else begin
         t2Ctrl_q[5:0] <= ctrlWr[5:0];
         t2Ctrl_q[T2C_OVF] <= ctrlWr[T2C_OVF] | setOvf;
         t2Ctrl_q[T2C_EXF] <= ctrlWr[T2C_EXF] | trgEvent;
      end
   end

   // ************************************************************
   // interrupts
   // ************************************************************
   wire [1:0] irqEvents = {trgEvent, setOvf};
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         irqStat_q <= 2'b00;
         irqMask_q <= 2'b00;
         irq       <= 1'b0;
      end else begin
         // event sticky, write one to clear
         irqStat_q <= (irqStat_q & ~(wrStat ? regWdata[1:0] : 2'b00)) | irqEvents;
         if (wrMask) irqMask_q <= regWdata[1:0];
         irq <= |(irqStat_q & irqMask_q);
      end
   end

   // ************************************************************
   // oscillator over twelve for mode 0
   // ************************************************************
   wire osc12Tick = (oscDiv_q == OSC_DIV12_LAST);
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         oscDiv_q <= 4'h0;
      end else begin
         oscDiv_q <= osc12Tick ? 4'h0 : oscDiv_q + 4'h1;
      end
   end

   // ************************************************************
   // per channel: generator, buffer, clock selection
   // ************************************************************
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         logic       genTick;
         logic [1:0] mode;
         logic       uartMode13;
         logic       txSrc;
         logic       rxSrc;
         logic       txPre;
         logic       rxPre;
         logic       dbl;

         baud_generator u_gen (
            .ref_clk     (ref_clk),
            .reset_n     (reset_n),
            .run         (genCtrl_q[ch][GC_RUN]),
            .fast        (genCtrl_q[ch][GC_FAST]),
            .reloadValue (brgReload_q[ch]),
            .tick        (genTick)
         );

         assign mode       = serCtrl_q[ch][SC_MODE_L +: 2];
         assign uartMode13 = mode[0];
         assign dbl        = serCtrl_q[ch][SC_DOUBLE];
         // timer 2 drives channel 0 only; channel 1 uses timer 1
         assign txSrc = genCtrl_q[ch][GC_TXSEL] ? genTick :
                        ((ch == 0) && t2Ctrl_q[T2C_TX_CLOCK_SELECT]) ? t2Ovf : timer1Overflow;
         assign rxSrc = genCtrl_q[ch][GC_RXSEL] ? genTick :
                        ((ch == 0) && t2Ctrl_q[T2C_RCLK]) ? t2Ovf : timer1Overflow;
         assign txPre = uartMode13 ? txSrc :
                        (mode == 2'd0) ? (genCtrl_q[ch][GC_SRC] ? genTick : osc12Tick) : 1'b1;
         assign rxPre = uartMode13 ? rxSrc :
                        (mode == 2'd0) ? (genCtrl_q[ch][GC_SRC] ? genTick : osc12Tick) : 1'b1;

         // halve the ticks unless double rate in modes 1-3
         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               txHalf_q[ch]   <= 1'b0;
               rxHalf_q[ch]   <= 1'b0;
               txBitClock[ch] <= 1'b0;
               rxBitClock[ch] <= 1'b0;
            end else begin
               if (txPre) txHalf_q[ch] <= ~txHalf_q[ch];
               if (rxPre) rxHalf_q[ch] <= ~rxHalf_q[ch];
               txBitClock[ch] <= txPre & ((dbl && mode != 2'd0) | txHalf_q[ch]);
               rxBitClock[ch] <= rxPre & ((dbl && mode != 2'd0) | rxHalf_q[ch]);
            end
         end

         always_ff @(posedge ref_clk) begin
            if (!reset_n) begin
               brgReload_q[ch] <= RST_BYTE;
               genCtrl_q[ch]   <= 5'h00;
               serCtrl_q[ch]   <= 3'h0;
            end else begin
               if (wrBrl[ch]) brgReload_q[ch] <= regWdata;
               if (wrGen[ch]) genCtrl_q[ch]   <= regWdata[4:0];
               if (wrSer[ch]) serCtrl_q[ch]   <= regWdata[2:0];
            end
         end

         always_ff @(posedge ref_clk) begin
            if (wrBuf[ch]) uartBuf_q[ch] <= regWdata;
         end
      end
   endgenerate

   // ************************************************************
   // read mux, data one cycle after the strobe
   // ************************************************************
   logic [7:0] rdMux;
   always_comb begin
      unique case (regAddr)
         OFS_UART0_BUFFER:        rdMux = uartBuf_q[0];
         OFS_UART1_BUFFER:        rdMux = uartBuf_q[1];
         OFS_BRG0_RELOAD:         rdMux = brgReload_q[0];
         OFS_BRG1_RELOAD:         rdMux = brgReload_q[1];
         OFS_BRG0_CONTROL:        rdMux = {3'h0, genCtrl_q[0]};
         OFS_BRG1_CONTROL:        rdMux = {3'h0, genCtrl_q[1]};
         OFS_TIMER2_CONTROL:      rdMux = t2Ctrl_q;
         OFS_T2_RELOAD_LO:        rdMux = t2Reload_q[7:0];
         OFS_T2_RELOAD_HI:        rdMux = t2Reload_q[15:8];
         OFS_T2_COUNT_LO:         rdMux = t2Count_q[7:0];
         OFS_T2_COUNT_HI:         rdMux = t2Count_q[15:8];
         OFS_T1_CONTROL:          rdMux = {5'h00, serCtrl_q[0]};
         OFS_T1_CONTROL + 8'h04:  rdMux = {5'h00, serCtrl_q[1]};
         OFS_IRQ_STATUS:          rdMux = {6'h00, irqStat_q};
         OFS_IRQ_MASK:            rdMux = {6'h00, irqMask_q};
         default:                 rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         regRdata <= 8'h00;
      end else begin
         regRdata <= regRead ? rdMux : 8'h00;
      end
   end

endmodule : timer2_baud_clocking

// [tb/t2_baud_assertions.sv]
/*
 * Checker: port-level properties of the timer 2 and baud clock block.
 * Assumes: bound to timer2_baud_clocking, one clock, sync reset.
 */
`timescale 1ns/1ps
module t2_baud_checker
   import t2_baud_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset_n,
   // register port
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWdata,
   input  wire logic       regWrite,
   input  wire logic       regRead,
   input  wire logic [7:0] regRdata,
   // pins and outputs
   input  wire logic       count_input_pin,
   input  wire logic       ext_trigger_pin,
   input  wire logic       timer1Overflow,
   input  wire logic [1:0] txBitClock,
   input  wire logic [1:0] rxBitClock,
   input  wire logic       irq
);
   // ************************************************************
   // shadow of software-written control
   // ************************************************************
   logic [5:0] t2cQ;
   logic [4:0] genQ;
   logic [2:0] serQ;
   logic [7:0] maskQ;
   logic [7:0] reloadQ;
   logic [3:0] quietQ;
   logic       settled;

   // pipelines may still carry a pulse just after a write
   assign settled = serQ[2:1] == 2'b01 && quietQ == 4'hF;

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         t2cQ    <= '0;
         genQ    <= '0;
         serQ    <= '0;
         maskQ   <= '0;
         reloadQ <= '0;
         quietQ  <= '0;
      end else begin
         quietQ <= regWrite ? 4'h0 : (quietQ == 4'hF ? quietQ : quietQ + 4'h1);
         if (regWrite && regAddr == OFS_TIMER2_CONTROL) t2cQ <= regWdata[5:0];
         if (regWrite && regAddr == OFS_BRG0_CONTROL) genQ <= regWdata[4:0];
         if (regWrite && regAddr == OFS_T1_CONTROL) serQ <= regWdata[2:0];
         if (regWrite && regAddr == OFS_IRQ_MASK) maskQ <= regWdata;
         if (regWrite && regAddr == OFS_BRG0_RELOAD) reloadQ <= regWdata;
      end
   end

   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   sequence readOf(logic [7:0] a);
      regRead && regAddr == a;
   endsequence

   a_read_idle_zero: assert property (!$past(regRead) |-> regRdata == 8'h00)
      else $error("read data not zero outside a read");
   a_unmapped_zero: assert property (readOf(8'h00) |=> regRdata == 8'h00)
      else $error("unmapped read not zero");
   a_reload_readback: assert property (
      readOf(OFS_BRG0_RELOAD) |=> regRdata == $past(reloadQ))
      else $error("reload register readback wrong");
   a_t2ctrl_readback: assert property (
      readOf(OFS_TIMER2_CONTROL) |=> regRdata[5:0] == $past(t2cQ))
      else $error("timer 2 control readback wrong");
   a_irq_masked_off: assert property (
      maskQ == 8'h00 && $past(maskQ) == 8'h00 |-> !irq)
      else $error("interrupt high with all masked");
   a_t1_tx_source: assert property (
      settled && !t2cQ[4] && !genQ[3] && txBitClock[0]
      |-> $past(timer1Overflow) || $past(timer1Overflow, 2))
      else $error("transmit clock without timer 1 overflow");
   a_rx_t2_stopped: assert property (
      settled && t2cQ[5] && !t2cQ[2] && !genQ[2] |-> !rxBitClock[0])
      else $error("receive clock while timer 2 stopped");
   a_gen_stopped: assert property (
      settled && !genQ[4] && genQ[3] && genQ[2] |-> txBitClock[0] == 1'b0
      && rxBitClock[0] == 1'b0)
      else $error("bit clock while generator stopped");
endmodule : t2_baud_checker

bind timer2_baud_clocking t2_baud_checker chk (
   .ref_clk        (ref_clk),
   .reset_n        (reset_n),
   .regAddr        (regAddr),
   .regWdata       (regWdata),
   .regWrite       (regWrite),
   .regRead        (regRead),
   .regRdata       (regRdata),
   .count_input_pin(count_input_pin),
   .ext_trigger_pin(ext_trigger_pin),
   .timer1Overflow (timer1Overflow),
   .txBitClock     (txBitClock),
   .rxBitClock     (rxBitClock),
   .irq            (irq)
);

// [tb/pin_partner.sv]
/*
 * Partner: the external count and trigger pins, idle high (pulled up).
 * Assumes: tasks are called by the bench; pins move off the clock edge.
 */
`timescale 1ns/1ps
module pin_partner (
   // clock
   input  wire logic ref_clk,
   // pins
   output logic      countPin,
   output logic      trigPin
);
   initial begin
      countPin = 1'b1;
      trigPin  = 1'b1;
   end

   // each level held three cycles so the sampler sees it three times
   task automatic fall(input bit trig, input int n);
      for (int i = 0; i < 2 * n; i++) begin
         repeat (3) @(posedge ref_clk);
         #2;
         if (trig) trigPin = ~trigPin;
         else countPin = ~countPin;
      end
   endtask : fall
endmodule : pin_partner

// [tb/tb_top.sv]
/*
 * Testbench: register, timer, trigger, interrupt and bit clock checks.
 * Assumes: checker bound by its own file, pins from pin_partner.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   import t2_baud_pkg::*;
   typedef struct { logic [7:0] exp; bit chk; } note_s;
   logic       ref_clk, reset_n, regWrite, regRead, t1Ovf, countPin, trigPin, irq;
   logic [7:0] regAddr, regWdata, regRdata, a, b;
   logic [1:0] txClk, rxClk;
   int         miscompares, cmp_count, txCnt, rxCnt, ch1Cnt;
   int         seed = 21671;
   bit         winOn, rdPend;
   note_s      expQ[$];
   logic [7:0] gotQ[$];
   logic [7:0] rnd[4];
   logic [7:0] rwAddr[4] = '{8'h99, 8'h9A, 8'hBB, 8'hC1};
   logic [7:0] ctrlTab[3] = '{8'h04, 8'h14, 8'h24};

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   timer2_baud_clocking dut (.ref_clk(ref_clk), .reset_n(reset_n), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .count_input_pin(countPin), .ext_trigger_pin(trigPin), .timer1Overflow(t1Ovf),
      .txBitClock(txClk), .rxBitClock(rxClk), .irq(irq));
   pin_partner pins (.ref_clk(ref_clk), .countPin(countPin), .trigPin(trigPin));

   // ************************************************************
   // stimulus of the neighbour timer, scoreboard, pulse counting
   // ************************************************************
   always @(posedge ref_clk) begin : mon
      note_s n;
      t1Ovf <= !t1Ovf && (($random(seed) & 3) == 0);
      if (winOn) begin
         txCnt += txClk[0];
         rxCnt += rxClk[0];
         ch1Cnt += txClk[1] + rxClk[1];
      end
      if (rdPend) begin
         n = expQ.pop_front();
         gotQ.push_back(regRdata);
         if (n.chk) `CHK(regRdata, n.exp)
      end
      rdPend <= regRead;
   end

   task automatic wr(input logic [7:0] ad, dt);
      regAddr <= ad;
      regWdata <= dt;
      regWrite <= 1'b1;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      @(posedge ref_clk);
   endtask : wr

   // three cycles, so the monitor has stored the data on return
   task automatic rd(input logic [7:0] ad, ex, input bit ck = 1'b1);
      expQ.push_back('{ex, ck});
      regAddr <= ad;
      regRead <= 1'b1;
      @(posedge ref_clk);
      regRead <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : rd

   task automatic cnt(output logic [7:0] v);
      rd(OFS_T2_COUNT_LO, 8'h00, 1'b0);
      v = gotQ.pop_back();
   endtask : cnt

   task automatic pulse(input bit trig, input int n);
      pins.fall(trig, n);
      repeat (4) @(posedge ref_clk);
   endtask : pulse

   task automatic win(input int n);
      repeat (4) @(posedge ref_clk);
      txCnt = 0;
      rxCnt = 0;
      ch1Cnt = 0;
      winOn <= 1'b1;
      repeat (n) @(posedge ref_clk);
      winOn <= 1'b0;
      @(posedge ref_clk);
   endtask : win

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : complete_run

   initial begin
      repeat (20000) @(posedge ref_clk);
      miscompares++;
      complete_run();
   end

   initial begin
      {regAddr, regWdata, regWrite, regRead, t1Ovf, reset_n} = '0;
      foreach (rnd[i]) rnd[i] = $random(seed);
      repeat (8) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      rd(OFS_BRG0_RELOAD, 8'h00);
      rd(OFS_BRG1_RELOAD, 8'h00);
      rd(OFS_TIMER2_CONTROL, 8'h00);
      wr(8'h00, 8'hA5);
      rd(8'h00, 8'h00);
      foreach (rwAddr[i]) begin
         wr(rwAddr[i], rnd[i]);
         rd(rwAddr[i], rnd[i]);
      end
      cnt(a);
      cnt(b);
      `CHK(8'(b - a), 8'h00)
      wr(OFS_TIMER2_CONTROL, 8'h04);
      cnt(a);
      cnt(b);
      `CHK(8'(b - a), 8'h03)
      wr(OFS_TIMER2_CONTROL, 8'h06);
      cnt(a);
      pulse(1'b0, 5);
      cnt(b);
      `CHK(8'(b - a), 8'h05)
      // flag only without serial clock use; reload in every case
      for (int i = 0; i < 3; i++) begin
         wr(OFS_TIMER2_CONTROL, 8'h00);
         wr(OFS_T2_COUNT_LO, 8'hF0);
         wr(OFS_T2_COUNT_HI, 8'hFF);
         wr(OFS_T2_RELOAD_LO, 8'h34);
         wr(OFS_T2_RELOAD_HI, 8'h12);
         wr(OFS_TIMER2_CONTROL, ctrlTab[i]);
         repeat (24) @(posedge ref_clk);
         rd(OFS_TIMER2_CONTROL, ctrlTab[i] | (i == 0 ? 8'h80 : 8'h00));
         rd(OFS_T2_COUNT_HI, 8'h12);
      end
      wr(OFS_IRQ_MASK, 8'h01);
      @(posedge ref_clk);
      `CHK(irq, 1'b1)
      wr(OFS_IRQ_STATUS, 8'h01);
      @(posedge ref_clk);
      `CHK(irq, 1'b0)
      wr(OFS_TIMER2_CONTROL, 8'h00);
      wr(OFS_T2_COUNT_HI, 8'h00);
      wr(OFS_TIMER2_CONTROL, 8'h0C);
      pulse(1'b1, 1);
      rd(OFS_TIMER2_CONTROL, 8'h4C);
      rd(OFS_T2_COUNT_HI, 8'h12);
      wr(OFS_TIMER2_CONTROL, 8'h00);
      wr(OFS_T2_COUNT_HI, 8'h55);
      wr(OFS_TIMER2_CONTROL, 8'h0D);
      pulse(1'b1, 1);
      rd(OFS_TIMER2_CONTROL, 8'h4D);
      rd(OFS_T2_RELOAD_HI, 8'h55);
      wr(OFS_IRQ_MASK, 8'h02);
      @(posedge ref_clk);
      `CHK(irq, 1'b1)
      wr(OFS_IRQ_STATUS, 8'h02);
      @(posedge ref_clk);
      `CHK(irq, 1'b0)
      wr(OFS_IRQ_MASK, 8'h00);
      // transmit runs on timer 1; receive clock stays zero while timer 2 is selected for receive but stopped
      wr(OFS_T1_CONTROL, 8'h03);
      wr(OFS_BRG0_CONTROL, 8'h00);
      wr(OFS_TIMER2_CONTROL, 8'h00);
      win(400);
      `CHK(txCnt != 0, 1'b1)
      wr(OFS_TIMER2_CONTROL, 8'h20);
      win(400);
      `CHK(rxCnt, 0)
      wr(OFS_BRG0_RELOAD, 8'hFE);
      wr(OFS_BRG0_CONTROL, 8'h1E);
      win(400);
      `CHK(txCnt != 0 && rxCnt != 0, 1'b1)
      wr(OFS_BRG0_CONTROL, 8'h0E);
      win(400);
      `CHK(txCnt + rxCnt, 0)
      // channel 1 idles in mode 0 on the oscillator over twelve, halved
      `CHK(ch1Cnt inside {[32:34]}, 1'b1)
      // fast generator wraps every second clock once it has cycled
      wr(OFS_BRG0_CONTROL, 8'h1E);
      win(400);
      `CHK(txCnt inside {[199:201]}, 1'b1)
      wr(OFS_T1_CONTROL, 8'h02);
      win(400);
      `CHK(txCnt inside {[99:101]}, 1'b1)
      complete_run();
   end
endmodule : tb_top
